// ==== spe_engine.sv ====
`timescale 1ns/10ps
`default_nettype none

// Contract
// (R01) latch flag cleared: reset, disable, write end, protect-pin
// (R02) write-disable acts only at deselect
// (R03) status read repeats while selected
// (R04) status readable while busy, protect bits late
// (R05) status byte: ones, protect bits, latch, busy
// (R06) busy flag high during write cycles
// (R07) no writes while latch flag clear
// (R08) protect bits change only by status write
// (R09) protected region blocks array writes
// (R10) master deselects right after status data byte
// (R11) status write starts timed cycle, clears latch
// (R12) new protect bits after cycle completes
// (R13) status write alters only protect bits
// (R14) status write rejection conditions
// (R15) read takes opcode, address, shifts data
// (R16) read address advances and wraps to zero
// (R17) read ends anytime, refused while busy
// (R18) nine address bits at largest density
// (R19) array write starts at deselect on boundary
// (R20) page bytes consecutive, wrap in page
// (R21) array write rejection conditions
// (R22) erase phase then program phase
// (R23) msb first, fixed opcodes, bit3 ignored
// (R24) read/write opcodes carry top address bit
// (R25) sample rising edge, drive falling edge
// (R26) protect codes map to array regions
// (R27) sixteen byte pages
module spe_engine #(
    parameter int WRITE_TIME_NS = 5000000
) (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_mosi,
    input  wire logic i_wp_n,
    output logic      o_miso,
    output logic      o_miso_oe
);
    import spe_pkg::*;

    localparam int WRITE_CYC = (WRITE_TIME_NS / CLK_PERIOD_NS < 2) ? 2 : WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int ERASE_CYC = WRITE_CYC / 2;

    // non-volatile storage: not touched by reset
    logic [7:0]  mem_ff [MEM_BYTES] = '{default: DELIVERY_BYTE};
    logic [1:0]  bp_ff = BP_NONE;

    // link side, clocked by the serial clock
    logic        fresh_ff     = 1'b1;
    logic        frame_tog_ff = 1'b0;
    spe_frame_t  frm_ff;
    logic [6:0]  sh_ff;
    logic [7:0]  page_ff [PAGE_BYTES];
    logic [15:0] mask_ff;
    logic        refused_ff;
    spe_stat_t   st_s1_ff;
    spe_stat_t   st_s2_ff;
    logic        miso_ff;
    spe_stat_t   stat_w;

    wire [2:0]   cur_bit   = fresh_ff ? 3'h0 : frm_ff.bit_idx;
    wire [4:0]   cur_bytes = fresh_ff ? 5'h00 : frm_ff.bytes;
    wire [7:0]   rx_byte   = {sh_ff, i_mosi};
    wire         byte_done = (cur_bit == LAST_BIT);
    spe_cmd_t    lk_cmd;
    assign lk_cmd = spe_decode(frm_ff.op);
    wire [7:0]   status_lk = {STATUS_ONES, st_s2_ff};
    wire [7:0]   tx_byte   = (lk_cmd == CMD_STATUS_READ_CMD) ? status_lk : mem_ff[frm_ff.addr];
    // status stays readable during a write cycle; only array reads are refused
    wire         rd_phase  = !fresh_ff
                             && (((lk_cmd == CMD_STATUS_READ_CMD) && (frm_ff.bytes >= CMD_BYTES))
                             || ((lk_cmd == CMD_READ) && !refused_ff && (frm_ff.bytes >= SR_BYTES))); // [R04]
    wire         wr_load   = (lk_cmd == CMD_WRITE) && !refused_ff;

    // deselect marks the frame as over without needing a clock edge
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            fresh_ff <= 1'b1;
        end else begin
            fresh_ff <= 1'b0;
        end
    end

    // status crossing presets to busy so nothing is accepted before it settles
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            st_s1_ff <= LINK_IDLE_ST;
            st_s2_ff <= LINK_IDLE_ST;
        end else begin
            st_s1_ff <= stat_w;
            st_s2_ff <= st_s1_ff; // [R04]
        end
    end

    always_ff @(posedge i_sck) begin // [R25]
        frm_ff.bit_idx <= cur_bit + 3'h1;
        sh_ff          <= rx_byte[6:0]; // [R23]
        if (fresh_ff) begin
            mask_ff      <= 16'h0000;
            frm_ff.bytes <= 5'h00;
            // a stray edge while deselected (idle level changing) is no frame
            frame_tog_ff <= frame_tog_ff ^ !i_cs_n;
        end
        if (byte_done) begin
            frm_ff.bytes <= (cur_bytes == BYTES_SAT) ? cur_bytes : cur_bytes + 5'h01;
            case (cur_bytes)
                5'h00: begin
                    frm_ff.op  <= rx_byte;
                    refused_ff <= st_s2_ff.busy; // [R17]
                end
                5'h01: begin
                    frm_ff.addr    <= {frm_ff.op[OP_ADDR_BIT], rx_byte}; // [R15] [R18] [R24]
                    frm_ff.sr_data <= rx_byte;
                end
                default: begin
                    if (wr_load) begin
                        page_ff[frm_ff.addr[3:0]]   <= rx_byte;
                        mask_ff[frm_ff.addr[3:0]]   <= 1'b1;
                        frm_ff.addr[3:0]            <= frm_ff.addr[3:0] + 4'h1; // [R20] [R27]
                    end else if (lk_cmd == CMD_READ) begin
                        frm_ff.addr <= frm_ff.addr + 9'h001; // [R16]
                    end
                end
            endcase
        end
    end

    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            miso_ff <= 1'b0;
        end else begin
            miso_ff <= tx_byte[~frm_ff.bit_idx]; // [R03] [R25]
        end
    end

    assign o_miso    = miso_ff;
    assign o_miso_oe = !i_cs_n && rd_phase; // [R17]

    // system side
    logic        cs_s1_ff, cs_s2_ff, cs_s3_ff;
    logic        wp_s1_ff, wp_s2_ff;
    logic        wp_seen_ff;
    logic        wel_ff;
    logic        kind_sr_ff;
    logic [1:0]  pend_bp_ff;
    logic        tog_seen_ff;
    logic [15:0] wr_mask_ff;
    logic [4:0]  wr_page_ff;
    logic [31:0] cnt_ff;
    spe_state_t  state_ff;

    wire         busy      = (state_ff != ST_IDLE);
    wire         cs_rise   = cs_s2_ff && !cs_s3_ff;
    wire         cs_fall   = !cs_s2_ff && cs_s3_ff;
    spe_cmd_t    sys_cmd;
    assign sys_cmd = spe_decode(frm_ff.op);
    // deselect already marks the link side fresh, so a frame with clocks is told by the toggle
    wire         clocked   = (frame_tog_ff != tog_seen_ff);
    wire         boundary  = clocked && (frm_ff.bit_idx == 3'h0);
    wire         one_byte  = boundary && (frm_ff.bytes == CMD_BYTES);
    wire         may_write = wel_ff && !busy && !wp_seen_ff && wp_s2_ff;
    wire         write_enable_cmd_go   = cs_rise && one_byte && (sys_cmd == CMD_WRITE_ENABLE_CMD);
    wire         write_disable_cmd_go   = cs_rise && one_byte && (sys_cmd == CMD_WRITE_DISABLE_CMD); // [R02]
    wire         start_sr  = cs_rise && boundary && (frm_ff.bytes == SR_BYTES)
                             && (sys_cmd == CMD_STATUS_WRITE_CMD) && may_write; // [R07] [R14]
    wire         start_wr  = cs_rise && boundary && (frm_ff.bytes >= WR_MIN_BYTES)
                             && (sys_cmd == CMD_WRITE) && may_write
                             && !spe_protected(bp_ff, frm_ff.addr); // [R09] [R19] [R21] [R26]
    wire         cyc_end   = (state_ff == ST_PROG) && (cnt_ff == 32'h0);
    wire         erase_end = (state_ff == ST_ERASE) && (cnt_ff == 32'h0);

    assign stat_w = '{bp: bp_ff, write_latch_flag: wel_ff, busy: busy}; // [R05]

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cs_s1_ff   <= 1'b1;
            cs_s2_ff   <= 1'b1;
            cs_s3_ff   <= 1'b1;
            wp_s1_ff   <= 1'b1;
            wp_s2_ff   <= 1'b1;
            wp_seen_ff <= 1'b0;
            tog_seen_ff <= frame_tog_ff;
        end else begin
            cs_s1_ff   <= i_cs_n;
            cs_s2_ff   <= cs_s1_ff;
            cs_s3_ff   <= cs_s2_ff;
            wp_s1_ff   <= i_wp_n;
            wp_s2_ff   <= wp_s1_ff;
            wp_seen_ff <= cs_fall ? !wp_s2_ff : (wp_seen_ff || !wp_s2_ff); // [R14]
            tog_seen_ff <= cs_rise ? frame_tog_ff : tog_seen_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wel_ff <= 1'b0;
        end else if (!wp_s2_ff || write_disable_cmd_go || cyc_end) begin
            wel_ff <= 1'b0; // [R01] [R11]
        end else if (write_enable_cmd_go) begin
            wel_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= 32'h0;
            kind_sr_ff <= 1'b0;
            pend_bp_ff <= BP_NONE;
            wr_mask_ff <= 16'h0000;
            wr_page_ff <= 5'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start_sr || start_wr) begin
                        state_ff   <= start_sr ? ST_PROG : ST_ERASE; // [R06]
                        cnt_ff     <= start_sr ? 32'(WRITE_CYC - 1) : 32'(ERASE_CYC - 1);
                        kind_sr_ff <= start_sr;
                        pend_bp_ff <= frm_ff.sr_data[3:2]; // [R13]
                        // later frames reuse the link registers, so the cycle keeps its own copy
                        wr_mask_ff <= mask_ff;
                        wr_page_ff <= frm_ff.addr[8:4];
                    end
                end
                ST_ERASE: begin
                    if (erase_end) begin
                        state_ff <= ST_PROG; // [R22]
                        cnt_ff   <= 32'(WRITE_CYC - ERASE_CYC - 1);
                    end else begin
                        cnt_ff <= cnt_ff - 32'h1;
                    end
                end
                ST_PROG: begin
                    if (cyc_end) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 32'h1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // protect bits move only at the end of a timed cycle; array bytes at the end of the erase phase and at cycle end
    always_ff @(posedge i_clk) begin
        if (cyc_end && kind_sr_ff) begin
            bp_ff <= pend_bp_ff; // [R08] [R12]
        end
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if ((erase_end || (cyc_end && !kind_sr_ff)) && wr_mask_ff[i]) begin
                mem_ff[{wr_page_ff, 4'(i)}] <= erase_end ? ERASED_BYTE : page_ff[i]; // [R22]
            end
        end
    end

    property p_wp_clears_latch;
        @(posedge i_clk) disable iff (i_srst) !wp_s2_ff |=> !wel_ff;
    endproperty
    a_wp_clears_latch: assert property (p_wp_clears_latch) else $error("latch set with protect pin low"); // [R01]

    property p_cycle_needs_latch;
        @(posedge i_clk) disable iff (i_srst) $rose(busy) |-> $past(wel_ff) && $past(cs_rise);
    endproperty
    a_cycle_needs_latch: assert property (p_cycle_needs_latch) else $error("cycle began without latch"); // [R07]

    property p_end_clears_latch;
        @(posedge i_clk) disable iff (i_srst) $fell(busy) |-> !wel_ff;
    endproperty
    a_end_clears_latch: assert property (p_end_clears_latch) else $error("latch survived cycle end"); // [R11]

    property p_bp_late;
        @(posedge i_clk) disable iff (i_srst) (bp_ff != $past(bp_ff)) |-> $fell(busy) && $past(kind_sr_ff);
    endproperty
    a_bp_late: assert property (p_bp_late) else $error("protect bits moved outside status cycle end"); // [R12]

    property p_no_latch_no_cycle;
        @(posedge i_clk) disable iff (i_srst) cs_rise && !busy && !wel_ff |=> !busy;
    endproperty
    a_no_latch_no_cycle: assert property (p_no_latch_no_cycle) else $error("write accepted with latch clear"); // [R14]

    property p_protected_refused;
        @(posedge i_clk) disable iff (i_srst)
            cs_rise && !busy && (sys_cmd == CMD_WRITE) && spe_protected(bp_ff, frm_ff.addr) |=> !busy;
    endproperty
    a_protected_refused: assert property (p_protected_refused) else $error("write into protected area"); // [R21]

    property p_sr_length;
        @(posedge i_clk) disable iff (i_srst)
            cs_rise && !busy && (sys_cmd == CMD_STATUS_WRITE_CMD) && (frm_ff.bytes != SR_BYTES) |=> !busy;
    endproperty
    a_sr_length: assert property (p_sr_length) else $error("status write of wrong length accepted"); // [R10]

    property p_write_disable_cmd_clears;
        @(posedge i_clk) disable iff (i_srst) write_disable_cmd_go |=> !wel_ff;
    endproperty
    a_write_disable_cmd_clears: assert property (p_write_disable_cmd_clears) else $error("disable left latch set"); // [R02]

    property p_erase_then_prog;
        @(posedge i_clk) disable iff (i_srst) erase_end |=> (state_ff == ST_PROG);
    endproperty
    a_erase_then_prog: assert property (p_erase_then_prog) else $error("program phase missing"); // [R22]

    // counts busy cycles so the whole timed cycle is checked without a long repetition
    logic [31:0] busy_len_ff;
    always_ff @(posedge i_clk) begin
        if (i_srst || !busy) begin
            busy_len_ff <= 32'h0;
        end else begin
            busy_len_ff <= busy_len_ff + 32'h1;
        end
    end

    property p_cycle_length;
        @(posedge i_clk) disable iff (i_srst) $fell(busy) |-> (busy_len_ff == 32'(WRITE_CYC));
    endproperty
    a_cycle_length: assert property (p_cycle_length) else $error("timed cycle of wrong length"); // [R11]

    property p_wp_blocks_cycle;
        @(posedge i_clk) disable iff (i_srst) cs_rise && (wp_seen_ff || !wp_s2_ff) |=> !$rose(busy);
    endproperty
    a_wp_blocks_cycle: assert property (p_wp_blocks_cycle) else $error("write accepted with protect pin low"); // [R14]

    property p_sr_sets_bp;
        @(posedge i_clk) disable iff (i_srst) cyc_end && kind_sr_ff |=> (bp_ff == $past(pend_bp_ff));
    endproperty
    a_sr_sets_bp: assert property (p_sr_sets_bp) else $error("status write lost protect bits"); // [R13]

    property p_array_keeps_bp;
        @(posedge i_clk) disable iff (i_srst) cyc_end && !kind_sr_ff |=> $stable(bp_ff);
    endproperty
    a_array_keeps_bp: assert property (p_array_keeps_bp) else $error("array write moved protect bits"); // [R08]

    property p_latch_from_enable;
        @(posedge i_clk) disable iff (i_srst) $rose(wel_ff) |-> $past(write_enable_cmd_go);
    endproperty
    a_latch_from_enable: assert property (p_latch_from_enable) else $error("latch set without enable"); // [R07]

    c_sr_cycle: cover property (@(posedge i_clk) disable iff (i_srst) start_sr ##1 busy);
    c_wr_cycle: cover property (@(posedge i_clk) disable iff (i_srst) start_wr ##1 busy);
    c_cycle_done: cover property (@(posedge i_clk) disable iff (i_srst) $fell(busy));
    c_write_enable_cmd: cover property (@(posedge i_clk) disable iff (i_srst) write_enable_cmd_go ##1 wel_ff);
endmodule

`default_nettype wire

// ==== spe_pkg.sv ====
package spe_pkg;
    localparam int          ADDR_W        = 9;
    localparam int          PAGE_BYTES    = 16;
    localparam int          MEM_BYTES     = 512;
    localparam int          CLK_PERIOD_NS = 10;
    localparam logic [3:0]  OP_UPPER      = 4'h0;
    localparam logic [2:0]  OP_WRITE_ENABLE_CMD       = 3'h6;
    localparam logic [2:0]  OP_WRITE_DISABLE_CMD       = 3'h4;
    localparam logic [2:0]  OP_STATUS_READ_CMD       = 3'h5;
    localparam logic [2:0]  OP_STATUS_WRITE_CMD       = 3'h1;
    localparam logic [2:0]  OP_READ       = 3'h3;
    localparam logic [2:0]  OP_WRITE      = 3'h2;
    localparam int          OP_ADDR_BIT   = 3;
    localparam logic [3:0]  STATUS_ONES   = 4'hF;
    localparam logic [1:0]  BP_NONE       = 2'h0;
    localparam logic [1:0]  BP_QTR        = 2'h1;
    localparam logic [1:0]  BP_HALF       = 2'h2;
    localparam logic [8:0]  PROT_QTR_BASE = 9'h180;
    localparam logic [8:0]  PROT_HALF_BASE = 9'h100;
    localparam logic [4:0]  BYTES_SAT     = 5'h1F;
    localparam logic [4:0]  CMD_BYTES     = 5'h01;
    localparam logic [4:0]  SR_BYTES      = 5'h02;
    localparam logic [4:0]  WR_MIN_BYTES  = 5'h03;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    localparam logic [7:0]  ERASED_BYTE   = 8'h00;
    localparam logic [7:0]  DELIVERY_BYTE = 8'hFF;
    localparam logic [3:0]  LINK_IDLE_ST  = 4'h1;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_WRITE_ENABLE_CMD, CMD_WRITE_DISABLE_CMD, CMD_STATUS_READ_CMD, CMD_STATUS_WRITE_CMD, CMD_READ, CMD_WRITE
    } spe_cmd_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} spe_state_t;

    // what the link side leaves behind for the system side at deselect
    typedef struct packed {
        logic [7:0] op;
        logic [8:0] addr;
        logic [4:0] bytes;
        logic [2:0] bit_idx;
        logic [7:0] sr_data;
    } spe_frame_t;

    // {protect_size_hi, protect_size_lo, write_latch_flag, write_busy_flag}
    typedef struct packed {
        logic [1:0] bp;
        logic       write_latch_flag;
        logic       busy;
    } spe_stat_t;

    function automatic spe_cmd_t spe_decode(input logic [7:0] op);
        spe_cmd_t c;
        c = CMD_NONE;
        if (op[7:4] == OP_UPPER) begin
            case (op[2:0])
                OP_WRITE_ENABLE_CMD:  c = CMD_WRITE_ENABLE_CMD;
                OP_WRITE_DISABLE_CMD:  c = CMD_WRITE_DISABLE_CMD;
                OP_STATUS_READ_CMD:  c = CMD_STATUS_READ_CMD;
                OP_STATUS_WRITE_CMD:  c = CMD_STATUS_WRITE_CMD;
                OP_READ:  c = CMD_READ;
                OP_WRITE: c = CMD_WRITE;
                default:  c = CMD_NONE;
            endcase
        end
        return c;
    endfunction

    function automatic logic spe_protected(input logic [1:0] bp, input logic [8:0] a);
        logic p;
        case (bp)
            BP_NONE: p = 1'b0;
            BP_QTR:  p = (a >= PROT_QTR_BASE);
            BP_HALF: p = (a >= PROT_HALF_BASE);
            default: p = 1'b1;
        endcase
        return p;
    endfunction
endpackage

// ==== spe_spi_master.sv ====
`timescale 1ns/10ps
`default_nettype none

module spe_spi_master (
    input  wire logic i_miso,
    input  wire logic i_miso_oe,
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi
);
    logic cpol;
    logic oe_seen;

    initial begin
        cpol    = 1'b0;
        oe_seen = 1'b0;
        o_sck   = 1'b0;
        o_cs_n  = 1'b1;
        o_mosi  = 1'b0;
    end

    // sck changes outside frames only when cpol has changed; nbits taken from the top of tx
    task automatic xfer(input int nbits, input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        oe_seen = 1'b0;
        o_sck = cpol;
        #7;
        o_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            #16 o_sck = 1'b0;
            o_mosi = tx[63-i];
            #16 o_sck = 1'b1;
            rx[63-i] = i_miso;
            oe_seen = oe_seen | i_miso_oe;
        end
        #8;
        if (!cpol) begin
            o_sck = 1'b0;
        end
        // deselect before any further rising edge, so the count ends where the caller chose
        #4 o_cs_n = 1'b1;
        // released line must not keep showing the last bit
        o_mosi = ~o_mosi;
        #100;
    endtask
endmodule

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import spe_pkg::*;
    localparam int WT_NS = 2000;
    logic        i_clk;
    logic        i_srst;
    logic        i_wp_n;
    logic        sck, cs_n, mosi, miso, miso_oe;
    logic [63:0] rx;
    int          bad_count;
    int          num_checks;
    int          cycles;

    spe_engine #(.WRITE_TIME_NS(WT_NS)) spe_engine_inst (
        .i_clk(i_clk), .i_srst(i_srst), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi),
        .i_wp_n(i_wp_n), .o_miso(miso), .o_miso_oe(miso_oe));

    spe_spi_master spe_spi_master_inst (
        .i_miso(miso), .i_miso_oe(miso_oe), .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));

    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // long enough for every frame and write cycle several times over
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic go(input int n, input logic [63:0] tx);
        spe_spi_master_inst.xfer(n, tx, rx);
    endtask

    task automatic en();
        go(8, {8'h06, 56'h0});
    endtask

    task automatic sr(input string what, input logic [7:0] exp);
        go(16, {8'h05, 56'h0});
        chk(what, rx[55:48], exp);
    endtask

    task automatic wr(input logic [8:0] a, input int n, input logic [47:0] d);
        go(16 + 8 * n, {4'h0, a[8], 3'h2, a[7:0], d});
    endtask

    task automatic rd(input logic [8:0] a, input int n);
        go(16 + 8 * n, {4'h0, a[8], 3'h3, a[7:0], 48'h0});
    endtask

    // bounded poll of the busy flag through status reads
    task automatic idle();
        for (int i = 0; i < 20; i++) begin
            go(16, {8'h05, 56'h0});
            if (rx[48] === 1'b0) begin
                break;
            end
        end
        chk("busy", {7'h0, rx[48]}, 8'h00);
    endtask

    initial begin
        i_srst = 1'b1;
        i_wp_n = 1'b1;
        bad_count = 0;
        num_checks = 0;
        cycles = 0;
        repeat (8) @(negedge i_clk);
        i_srst = 1'b0;
        repeat (4) @(negedge i_clk);
        sr("status after reset", 8'hF0);
        go(8, {8'h0E, 56'h0});
        sr("latch set", 8'hF2);
        go(8, {8'h0C, 56'h0});
        sr("latch after disable", 8'hF0);
        wr(9'h010, 1, {8'h5A, 40'h0});
        idle();
        rd(9'h010, 1);
        chk("write without latch", rx[47:40], 8'hFF);
        en();
        wr(9'h1FE, 3, {24'hA1B2C3, 24'h0});
        sr("status during write", 8'hF3);
        rd(9'h1FE, 1);
        chk("read while busy", {7'h0, spe_spi_master_inst.oe_seen}, 8'h00);
        idle();
        sr("latch after write", 8'hF0);
        rd(9'h1FE, 3);
        chk("byte 1FE", rx[47:40], 8'hA1);
        chk("byte 1FF", rx[39:32], 8'hB2);
        chk("wrap to 000", rx[31:24], 8'hFF);
        chk("read drives output", {7'h0, spe_spi_master_inst.oe_seen}, 8'h01);
        rd(9'h1F0, 1);
        chk("page wrap", rx[47:40], 8'hC3);
        en();
        go(16, {8'h01, 8'hF7, 48'h0});
        sr("old protect while busy", 8'hF3);
        idle();
        sr("protect quarter", 8'hF4);
        en();
        wr(9'h180, 1, {8'h11, 40'h0});
        idle();
        en();
        wr(9'h17F, 1, {8'h22, 40'h0});
        idle();
        rd(9'h17F, 2);
        chk("below quarter", rx[47:40], 8'h22);
        chk("quarter blocked", rx[39:32], 8'hFF);
        en();
        go(15, {8'h01, 8'h00, 48'h0});
        go(24, {8'h01, 8'h00, 8'h00, 40'h0});
        idle();
        sr("misframed status write", 8'hF6);
        @(negedge i_clk) i_wp_n = 1'b0;
        repeat (4) @(negedge i_clk);
        sr("latch under protect pin", 8'hF4);
        en();
        go(16, {8'h01, 8'h00, 48'h0});
        idle();
        sr("protect pin blocks status write", 8'hF4);
        @(negedge i_clk) i_wp_n = 1'b1;
        en();
        go(16, {8'h01, 8'h00, 48'h0});
        idle();
        spe_spi_master_inst.cpol = 1'b1;
        sr("idle-high clock read", 8'hF0);
        summarize();
    end
endmodule

`default_nettype wire
